// >>> verilog/eec_top.sv
// eec_top: data eeprom controller with axi4-lite access to the control
// register, interrupt registers and the 256-byte eeprom window.
// assumes a single 100 MHz clock, synchronous active-low reset.
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module eec_top
  import eec_pkg::*;
#(
  parameter int ERASE_CYCLES = ERASE_CYCLES_DEF,
  parameter int PROG_CYCLES = PROG_CYCLES_DEF
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // cpu power and interrupt handshake
  input wire logic wait_for_interrupt_instr,
  input wire logic halt_instr,
  input wire logic irq_vector_fetch,
  output logic irq,
  output logic wait_mode,
  output logic halt_mode
);

  localparam logic [CNT_W-1:0] ERASE_LOAD = CNT_W'(ERASE_CYCLES - 1);
  localparam logic [CNT_W-1:0] PROG_LOAD = CNT_W'(PROG_CYCLES - 1);

  // write channel state
  logic awready_ff;
  logic wready_ff;
  logic aw_got_ff;
  logic w_got_ff;
  logic [ADDR_W-1:0] aw_addr_ff;
  logic [DATA_W-1:0] w_data_ff;
  logic [3:0] w_strb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  // read channel state
  logic arready_ff;
  logic rvalid_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic [1:0] rresp_ff;
  // block state
  eec_csr_t csr_ff;
  eec_state_t state_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic [ROW_W-1:0] row_ff;
  logic [7:0] latch_ff [LATCH_N];
  logic [LATCH_N-1:0] lmask_ff;
  logic [7:0] col_rd [LATCH_N];
  logic [7:0] stat_ff;
  logic [7:0] mask_ff;
  logic irq_ff;
  logic wait_ff;
  logic halt_ff;

  // decoded write and events
  logic wr_exec;
  logic wr_csr;
  logic wr_stat;
  logic wr_mask;
  logic wr_ee;
  logic ee_latch_wr;
  logic prog_done;
  logic prog_abort;
  logic latch_clr;
  logic [COL_W-1:0] wr_col;
  logic [7:0] wr_byte;
  eec_csr_t nxt_csr;
  logic [7:0] nxt_stat;

  assign wr_exec = aw_got_ff && w_got_ff && !bvalid_ff;
  assign wr_byte = w_data_ff[7:0];
  assign wr_col = aw_addr_ff[EE_IDX_LSB +: COL_W];
  assign wr_csr = wr_exec && w_strb_ff[0] && (aw_addr_ff == CSR_OFF);
  assign wr_stat = wr_exec && w_strb_ff[0] && (aw_addr_ff == IRQ_STAT_OFF);
  assign wr_mask = wr_exec && w_strb_ff[0] && (aw_addr_ff == IRQ_MASK_OFF);
  assign wr_ee = wr_exec && w_strb_ff[0]
    && (aw_addr_ff[EE_SEL_MSB:EE_SEL_LSB] == EE_SEL_VAL);
  // latch only in latch mode while no cycle runs
  assign ee_latch_wr = wr_ee && csr_ff.lat && !csr_ff.program_start;
  assign prog_done = (state_ff == ST_PROG) && (cnt_ff == '0) && !halt_instr;
  // software clear of start or halt abandons the cycle
  assign prog_abort = (state_ff != ST_IDLE)
    && (halt_instr || (wr_csr && !wr_byte[CSR_PGM_BIT]));
  assign latch_clr = prog_done || (csr_ff.lat && !nxt_csr.lat);

  // next control register value
  always_comb begin
    nxt_csr = csr_ff;
    if (wr_csr) begin
      nxt_csr.ie = wr_byte[CSR_IE_BIT];
      if (wr_byte[CSR_LAT_BIT]) begin
        nxt_csr.lat = 1'b1;
      end else if (!csr_ff.program_start) begin
        nxt_csr.lat = 1'b0;
      end
      if (wr_byte[CSR_PGM_BIT] && csr_ff.lat) begin
        nxt_csr.program_start = 1'b1;
      end else if (!wr_byte[CSR_PGM_BIT]) begin
        nxt_csr.program_start = 1'b0;
      end
    end
    if (halt_instr) begin
      nxt_csr.program_start = 1'b0;
    end
    if (prog_done) begin
      nxt_csr.program_start = 1'b0;
      nxt_csr.lat = 1'b0;
    end
  end

  // control/status register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      csr_ff <= eec_csr_t'(CSR_RESET[2:0]);
    end else begin
      csr_ff <= nxt_csr;
    end
  end

  // programming sequencer: erase then program, self timed
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= ST_IDLE;
      cnt_ff <= '0;
    end else if (prog_abort) begin
      state_ff <= ST_IDLE;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (!csr_ff.program_start && nxt_csr.program_start) begin
            state_ff <= ST_ERASE;
            cnt_ff <= ERASE_LOAD;
          end
        end
        ST_ERASE: begin
          if (cnt_ff == '0) begin
            state_ff <= ST_PROG;
            cnt_ff <= PROG_LOAD;
          end else begin
            cnt_ff <= cnt_ff - 1'b1;
          end
        end
        ST_PROG: begin
          if (cnt_ff == '0) begin
            state_ff <= ST_IDLE;
          end else begin
            cnt_ff <= cnt_ff - 1'b1;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // row of the latest latched write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      row_ff <= '0;
    end else if (ee_latch_wr) begin
      row_ff <= aw_addr_ff[EE_IDX_LSB+COL_W +: ROW_W];
    end
  end

  // sixteen write latches, each a wired AND of its writes
  for (genvar gi = 0; gi < LATCH_N; gi++) begin : g_latch
    always_ff @(posedge aclk) begin
      if (!aresetn || latch_clr) begin
        latch_ff[gi] <= BYTE_ERASED;
        lmask_ff[gi] <= 1'b0;
      end else if (ee_latch_wr && (wr_col == COL_W'(gi))) begin
        latch_ff[gi] <= latch_ff[gi] & wr_byte;
        lmask_ff[gi] <= 1'b1;
      end
    end

    // cell array: erase then program the flagged columns of the row
    logic [7:0] col_cells [EE_BYTES/LATCH_N];
    always_ff @(posedge aclk) begin
      if (lmask_ff[gi] && (cnt_ff == '0) && !prog_abort) begin
        if (state_ff == ST_ERASE) begin
          col_cells[row_ff] <= BYTE_ERASED;
        end else if (state_ff == ST_PROG) begin
          col_cells[row_ff] <= latch_ff[gi];
        end
      end
    end
    assign col_rd[gi] = col_cells[s_axi_araddr[EE_IDX_LSB+COL_W +: ROW_W]];
  end

  // next interrupt status, set wins over clear
  always_comb begin
    nxt_stat = stat_ff;
    if (prog_done && csr_ff.ie) begin
      nxt_stat[STAT_DONE_BIT] = 1'b1;
    end else if ((wr_stat && wr_byte[STAT_DONE_BIT]) || irq_vector_fetch) begin
      nxt_stat[STAT_DONE_BIT] = 1'b0;
    end
  end

  // interrupt status, mask and request
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_ff <= STAT_RESET;
      mask_ff <= MASK_RESET;
      irq_ff <= 1'b0;
    end else begin
      stat_ff <= nxt_stat;
      if (wr_mask) begin
        mask_ff <= wr_byte & STAT_USED;
      end
      irq_ff <= |(nxt_stat & mask_ff);
    end
  end

  // wait and halt mode indication
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wait_ff <= 1'b0;
      halt_ff <= 1'b0;
    end else begin
      wait_ff <= wait_for_interrupt_instr && (state_ff == ST_IDLE);
      halt_ff <= halt_instr;
    end
  end

  // axi write address/data capture and response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      aw_addr_ff <= '0;
      w_data_ff <= '0;
      w_strb_ff <= '0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && awready_ff) begin
        aw_got_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
        awready_ff <= 1'b0;
      end else if (!aw_got_ff && !bvalid_ff) begin
        awready_ff <= 1'b1;
      end
      if (s_axi_wvalid && wready_ff) begin
        w_got_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
        wready_ff <= 1'b0;
      end else if (!w_got_ff && !bvalid_ff) begin
        wready_ff <= 1'b1;
      end
      if (wr_exec) begin
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= (wr_csr || wr_stat || wr_mask || wr_ee || !w_strb_ff[0])
          && (aw_addr_ff[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // read decode; latches have no read path
  logic [DATA_W-1:0] rd_data;
  logic [1:0] rd_resp;
  always_comb begin
    rd_data = '0;
    rd_resp = RESP_OKAY;
    if (s_axi_araddr == CSR_OFF) begin
      rd_data = DATA_W'(csr_ff);
    end else if (s_axi_araddr == IRQ_STAT_OFF) begin
      rd_data = DATA_W'(stat_ff);
    end else if (s_axi_araddr == IRQ_MASK_OFF) begin
      rd_data = DATA_W'(mask_ff);
    end else if (s_axi_araddr[EE_SEL_MSB:EE_SEL_LSB] == EE_SEL_VAL) begin
      if (csr_ff.lat || s_axi_arprot[PROT_INSTR_BIT]) begin
        rd_resp = RESP_SLVERR;
      end else begin
        rd_data = DATA_W'(col_rd[s_axi_araddr[EE_IDX_LSB +: COL_W]]);
      end
    end else begin
      rd_resp = RESP_SLVERR;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= '0;
      rresp_ff <= RESP_OKAY;
    end else begin
      if (s_axi_arvalid && arready_ff) begin
        arready_ff <= 1'b0;
        rvalid_ff <= 1'b1;
        rdata_ff <= rd_data;
        rresp_ff <= rd_resp;
      end else if (rvalid_ff && s_axi_rready) begin
        rvalid_ff <= 1'b0;
        arready_ff <= 1'b1;
      end else if (!rvalid_ff) begin
        arready_ff <= 1'b1;
      end
    end
  end

  // outputs
  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign irq = irq_ff;
  assign wait_mode = wait_ff;
  assign halt_mode = halt_ff;
endmodule : eec_top
`default_nettype wire

// >>> verilog/eec_pkg.sv
// eec_pkg: constants, types and register map of the data eeprom controller.
// assumes a 100 MHz system clock and a 32-bit axi4-lite register bus.
`default_nettype none
package eec_pkg;
  // bus geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int PROT_INSTR_BIT = 2;
  // register and memory window byte addresses
  localparam logic [ADDR_W-1:0] CSR_OFF = 12'h02C;
  localparam logic [ADDR_W-1:0] IRQ_STAT_OFF = 12'h080;
  localparam logic [ADDR_W-1:0] IRQ_MASK_OFF = 12'h084;
  localparam logic [ADDR_W-1:0] EE_BASE = 12'h400;
  localparam int EE_SEL_MSB = 11;
  localparam int EE_SEL_LSB = 10;
  localparam logic [1:0] EE_SEL_VAL = 2'h1;
  localparam int EE_IDX_MSB = 9;
  localparam int EE_IDX_LSB = 2;
  // eeprom geometry
  localparam int EE_BYTES = 256;
  localparam int LATCH_N = 16;
  localparam int COL_W = 4;
  localparam int ROW_W = 4;
  localparam logic [7:0] BYTE_ERASED = 8'hFF;
  // control/status field positions and reset
  localparam int CSR_PGM_BIT = 0;
  localparam int CSR_LAT_BIT = 1;
  localparam int CSR_IE_BIT = 2;
  localparam logic [7:0] CSR_RESET = 8'h00;
  // interrupt status/mask layout
  localparam int STAT_DONE_BIT = 0;
  localparam logic [7:0] STAT_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h01;
  localparam logic [7:0] STAT_USED = 8'h01;
  // programming phase lengths in clock cycles
  localparam int ERASE_CYCLES_DEF = 20000;
  localparam int PROG_CYCLES_DEF = 20000;
  localparam int CNT_W = 20;

  typedef struct packed {
    logic ie;
    logic lat;
    logic program_start;
  } eec_csr_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ERASE = 2'b01,
    ST_PROG = 2'b10
  } eec_state_t;
endpackage : eec_pkg
`default_nettype wire

// >>> bench/eec_cpu_model.sv
// eec_cpu_model: cpu side of the eeprom controller (wfi, halt, vector).
// assumes bench drives the request inputs after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module eec_cpu_model (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bench requests and irq
  input wire logic take_en,
  input wire logic wfi_req,
  input wire logic halt_req,
  input wire logic irq,
  // cpu outputs
  output logic irq_vector_fetch,
  output logic wait_for_interrupt_instr,
  output logic halt_instr
);
  logic taken_ff;
  // one vector fetch pulse per irq while take_en is set; wfi and halt requests are registered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_vector_fetch <= 1'h0;
      taken_ff <= 1'h0;
      wait_for_interrupt_instr <= 1'h0;
      halt_instr <= 1'h0;
    end else begin
      irq_vector_fetch <= irq && take_en && !taken_ff && !irq_vector_fetch;
      taken_ff <= irq && (taken_ff || irq_vector_fetch);
      wait_for_interrupt_instr <= wfi_req;
      halt_instr <= halt_req;
    end
  end
endmodule : eec_cpu_model
`default_nettype wire

// >>> bench/eec_assertions.sv
// eec_assertions: port-level checks of the eeprom controller.
// assumes it is bound onto eec_top; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module eec_checker
  import eec_pkg::*;
#(
  parameter int ERASE_CYCLES = 8,
  parameter int PROG_CYCLES = 8
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // read channel
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [DATA_W-1:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // cpu side
  input wire logic irq_vector_fetch,
  input wire logic irq,
  input wire logic halt_instr,
  input wire logic halt_mode,
  input wire logic wait_for_interrupt_instr,
  input wire logic wait_mode
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic ar_take;
  assign ar_take = s_axi_arvalid && s_axi_arready;
  rd_next_a: assert property (ar_take |=> s_axi_rvalid)
    else $error("read answer late");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
  fetch_refuse_a: assert property (ar_take
    && s_axi_arprot[PROT_INSTR_BIT]
    && s_axi_araddr[EE_SEL_MSB:EE_SEL_LSB] == EE_SEL_VAL
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == '0)
    else $error("code fetch not refused");
  csr_zero_a: assert property (ar_take && s_axi_araddr == CSR_OFF |=>
    s_axi_rdata[31:3] == '0) else $error("reserved bits set");
  vec_clear_a: assert property (irq_vector_fetch |-> ##2 !irq)
    else $error("irq kept after vector");
  halt_in_a: assert property ($rose(halt_instr) |=> halt_mode)
    else $error("halt not entered");
  halt_out_a: assert property (!halt_instr [*2] |-> !halt_mode)
    else $error("halt kept");
  wait_src_a: assert property (wait_mode
    |-> $past(wait_for_interrupt_instr)) else $error("wait without request");
  cover property ($rose(irq));
  cover property ($rose(wait_mode));
  cover property ($rose(halt_mode));
endmodule : eec_checker
bind eec_top eec_checker #(
  .ERASE_CYCLES(ERASE_CYCLES),
  .PROG_CYCLES(PROG_CYCLES)
) chk_u (
  .aclk(aclk),
  .aresetn(aresetn),
  .s_axi_araddr(s_axi_araddr),
  .s_axi_arprot(s_axi_arprot),
  .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready),
  .irq_vector_fetch(irq_vector_fetch),
  .irq(irq),
  .halt_instr(halt_instr),
  .halt_mode(halt_mode),
  .wait_for_interrupt_instr(wait_for_interrupt_instr),
  .wait_mode(wait_mode)
);
`default_nettype wire

// >>> bench/tb_eec_top.sv
// tb_eec_top: register-level tests of the eeprom controller.
// assumes eec_top, eec_cpu_model and the bound checker are compiled.
`timescale 1ns/1ps
`default_nettype none
module tb_eec_top;
  import eec_pkg::*;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0;
  logic [DATA_W-1:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic wait_for_interrupt_instr, halt_instr, irq_vector_fetch;
  logic irq, wait_mode, halt_mode;
  logic take_en = 1'h0, wfi_req = 1'h0, halt_req = 1'h0;
  logic [1:0] bresp_seen = 2'h0;
  int n_fail = 0;
  int checked = 0;
  always #5 aclk = ~aclk;
  eec_top #(.ERASE_CYCLES(8), .PROG_CYCLES(8)) dut_u (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awprot(s_axi_awprot),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arprot(s_axi_arprot),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wait_for_interrupt_instr(wait_for_interrupt_instr),
    .halt_instr(halt_instr),
    .irq_vector_fetch(irq_vector_fetch),
    .irq(irq),
    .wait_mode(wait_mode),
    .halt_mode(halt_mode)
  );
  eec_cpu_model cpu_u (.aclk(aclk), .aresetn(aresetn), .take_en(take_en),
    .wfi_req(wfi_req), .halt_req(halt_req), .irq(irq),
    .irq_vector_fetch(irq_vector_fetch), .halt_instr(halt_instr),
    .wait_for_interrupt_instr(wait_for_interrupt_instr));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    bresp_seen = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask : wr
  task automatic rc(input logic [11:0] a, input logic [2:0] p,
                    input logic [7:0] d, input logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arprot <= p;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
    chk(s_axi_rdata, {24'h0, d});
    chk(32'(s_axi_rresp), 32'(r));
  endtask : rc
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc
  task automatic wait_irq;
    for (int i = 0; i < 100 && irq !== 1'h1; i++) @(posedge aclk);
  endtask : wait_irq
  task automatic end_of_test;
    $display("comparisons %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test
  initial begin
    cyc(5000);
    n_fail++;
    end_of_test();
  end
  initial begin
    cyc(6);
    aresetn <= 1'h1;
    rc(CSR_OFF, 3'h0, 8'h00, RESP_OKAY);
    rc(IRQ_MASK_OFF, 3'h0, 8'h01, RESP_OKAY);
    rc(IRQ_STAT_OFF, 3'h0, 8'h00, RESP_OKAY);
    wr(CSR_OFF, 8'hFF);
    rc(CSR_OFF, 3'h0, 8'h06, RESP_OKAY);
    $display("test reset and register done");
    wr(12'h440, 8'hF0);
    wr(12'h440, 8'h3C);
    wr(12'h444, 8'hA5);
    rc(12'h440, 3'h0, 8'h00, RESP_SLVERR);
    wr(CSR_OFF, 8'h07);
    rc(CSR_OFF, 3'h0, 8'h07, RESP_OKAY);
    wait_irq();
    chk(32'(irq), 32'h1);
    rc(CSR_OFF, 3'h0, 8'h04, RESP_OKAY);
    rc(12'h440, 3'h0, 8'h30, RESP_OKAY);
    rc(12'h444, 3'h0, 8'hA5, RESP_OKAY);
    rc(IRQ_STAT_OFF, 3'h0, 8'h01, RESP_OKAY);
    $display("test programming done");
    wr(IRQ_MASK_OFF, 8'h00);
    cyc(2);
    chk(32'(irq), 32'h0);
    wr(IRQ_MASK_OFF, 8'h01);
    cyc(2);
    chk(32'(irq), 32'h1);
    wr(IRQ_STAT_OFF, 8'h01);
    cyc(2);
    chk(32'(irq), 32'h0);
    $display("test interrupt done");
    wr(12'h440, 8'h00);
    chk(32'(bresp_seen), 32'(RESP_OKAY));
    rc(12'h440, 3'h0, 8'h30, RESP_OKAY);
    wr(12'h100, 8'h00);
    chk(32'(bresp_seen), 32'(RESP_SLVERR));
    rc(12'h440, 3'h4, 8'h00, RESP_SLVERR);
    rc(12'h100, 3'h0, 8'h00, RESP_SLVERR);
    $display("test refusals done");
    wr(CSR_OFF, 8'h06);
    wr(12'h444, 8'h0F);
    wr(CSR_OFF, 8'h04);
    wr(CSR_OFF, 8'h06);
    wr(CSR_OFF, 8'h07);
    wfi_req <= 1'h1;
    cyc(3);
    chk(32'(wait_mode), 32'h0);
    take_en <= 1'h1;
    wait_irq();
    cyc(4);
    chk(32'(irq), 32'h0);
    chk(32'(wait_mode), 32'h1);
    rc(12'h444, 3'h0, 8'hA5, RESP_OKAY);
    wfi_req <= 1'h0;
    take_en <= 1'h0;
    $display("test wait and vector done");
    wr(CSR_OFF, 8'h06);
    wr(12'h448, 8'h00);
    wr(CSR_OFF, 8'h07);
    wr(CSR_OFF, 8'h05);
    rc(CSR_OFF, 3'h0, 8'h07, RESP_OKAY);
    halt_req <= 1'h1;
    cyc(3);
    chk(32'(halt_mode), 32'h1);
    rc(CSR_OFF, 3'h0, 8'h06, RESP_OKAY);
    halt_req <= 1'h0;
    wr(CSR_OFF, 8'h00);
    rc(CSR_OFF, 3'h0, 8'h00, RESP_OKAY);
    $display("test halt done");
    end_of_test();
  end
endmodule : tb_eec_top
`default_nettype wire
